// file: inc/pio_pkg.sv
// Purpose: Constants shared by the parallel port block.
// Assumes: Byte-wide register port, word index equals printed offset.
// Notes:   Offsets without a printed value were placed after port E.
package pio_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] PIO_OFS_A_LATCH = 4'h0;
  localparam logic [3:0] PIO_OFS_B_LATCH = 4'h1;
  localparam logic [3:0] PIO_OFS_C_LATCH = 4'h2;
  localparam logic [3:0] PIO_OFS_D_INPUT = 4'h3;
  localparam logic [3:0] PIO_OFS_A_DIR   = 4'h4;
  localparam logic [3:0] PIO_OFS_B_DIR   = 4'h5;
  localparam logic [3:0] PIO_OFS_C_DIR   = 4'h6;
  localparam logic [3:0] PIO_OFS_E_DIR   = 4'h7;
  localparam logic [3:0] PIO_OFS_E_LATCH = 4'h8;

  // Register port widths.
  localparam int PIO_ADDR_W = 4;
  localparam int PIO_DATA_W = 8;

  // Direction registers clear to all inputs at reset.
  localparam logic [7:0] PIO_DIR_RST = 8'h00;

endpackage : pio_pkg

// file: hdl/pio_ports.sv
// Purpose: Parallel ports A to E with latches, direction bits and pins.
// Assumes: Pin inputs are synchronous to clk; register reads have one
//          cycle of latency and never stall.
// Notes:   Data latches have no reset; direction registers and read data clear.

// Theory of operation.
// Every bidirectional port is built from the same three parts: a data
// latch that software writes, a direction register that software writes
// and reset clears, and a pin slice that turns the two into an enable
// and a drive value.  The read path never returns the direction-blind
// latch alone: each bit is taken from the latch where the pin drives and
// from the pin where it listens.
//
// Hazards a user must know.
// The data latches are left alone by reset on purpose, so that software
// can preload an output level before reset is released.  The flip side is
// that a latch holds an unknown level until first written.  Since reset
// clears the direction bits, no unknown level ever reaches a pin, but a
// pin turned to output before its latch is written drives whatever the
// latch happens to hold.  Loading the latch first avoids that glitch.
//
// Port D has no drivers at all.  Its latch is storage that software may
// write, but a read always returns the pin levels, so the stored value is
// never visible on the register port.
//
// Port E pins may be claimed by a shared peripheral.  A claimed pin takes
// the peripheral's enable and value, while the port E direction bit still
// chooses whether a read returns the latch or the pin.  Software reading
// a claimed output pin with its direction bit clear sees the pin level,
// which is the peripheral's drive.
//
// Register port.
// A write lands on the edge that samples the write strobe; the new value
// shows on the pins in the following cycle.  A read samples the pins on
// the edge that samples the read strobe and holds the result on the read
// data port from then until the next read.  Unmapped indices read zero
// and ignore writes.  The port never stalls, so back-to-back accesses in
// any order are legal.
//
// Pin inputs are taken as synchronous to the clock; anything that comes
// from the board must be synchronised before it reaches this block.
//
// Reduced-pin builds leave some pins unbonded.  Software is expected to
// set those pins to outputs so that they do not float; the block itself
// treats them like any other pin.

module pio_ports #(
  parameter int PA_W = 8,
  parameter int PB_W = 8,
  parameter int PC_W = 7,
  parameter int PD_W = 7,
  parameter int PE_W = 8
) (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Register port.
  input  wire logic [pio_pkg::PIO_ADDR_W-1:0] reg_addr,
  input  wire logic [pio_pkg::PIO_DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [pio_pkg::PIO_DATA_W-1:0] reg_rdata,
  // Port A pins.
  input  wire logic [PA_W-1:0]              pa_in,
  output logic      [PA_W-1:0]              pa_out,
  output logic      [PA_W-1:0]              pa_oe,
  // Port B pins.
  input  wire logic [PB_W-1:0]              pb_in,
  output logic      [PB_W-1:0]              pb_out,
  output logic      [PB_W-1:0]              pb_oe,
  // Port C pins.
  input  wire logic [PC_W-1:0]              pc_in,
  output logic      [PC_W-1:0]              pc_out,
  output logic      [PC_W-1:0]              pc_oe,
  // Port D pins, input only.
  input  wire logic [PD_W-1:0]              pd_in,
  // Port E pins and peripheral sharing.
  input  wire logic [PE_W-1:0]              pe_in,
  output logic      [PE_W-1:0]              pe_out,
  output logic      [PE_W-1:0]              pe_oe,
  input  wire logic [PE_W-1:0]              pe_periph_own,
  input  wire logic [PE_W-1:0]              pe_periph_oe,
  input  wire logic [PE_W-1:0]              pe_periph_out
);
  import pio_pkg::*;

  localparam int DW = PIO_DATA_W;

  logic [PA_W-1:0] port_a_latch_ff;
  logic [PB_W-1:0] port_b_latch_ff;
  logic [PC_W-1:0] port_c_latch_ff;
  logic [PD_W-1:0] port_d_input_ff;
  logic [PE_W-1:0] port_e_latch_ff;
  logic [PA_W-1:0] port_a_direction_ff;
  logic [PB_W-1:0] port_b_direction_ff;
  logic [PC_W-1:0] port_c_direction_ff;
  logic [PE_W-1:0] port_e_direction_ff;
  logic [DW-1:0]   reg_rdata_ff;
  logic [DW-1:0]   nxt_reg_rdata;

  // Per-bit read selection: latch where output, pin where input.
  function automatic logic [DW-1:0] pio_mux(input logic [DW-1:0] dir,
                                            input logic [DW-1:0] lat,
                                            input logic [DW-1:0] pin);
    pio_mux = (dir & lat) | (~dir & pin);
  endfunction : pio_mux

  // Address decode strobes.
  wire wr_a_lat = reg_wr && (reg_addr == PIO_OFS_A_LATCH);
  wire wr_b_lat = reg_wr && (reg_addr == PIO_OFS_B_LATCH);
  wire wr_c_lat = reg_wr && (reg_addr == PIO_OFS_C_LATCH);
  wire wr_d_lat = reg_wr && (reg_addr == PIO_OFS_D_INPUT);
  wire wr_e_lat = reg_wr && (reg_addr == PIO_OFS_E_LATCH);
  wire wr_a_dir = reg_wr && (reg_addr == PIO_OFS_A_DIR);
  wire wr_b_dir = reg_wr && (reg_addr == PIO_OFS_B_DIR);
  wire wr_c_dir = reg_wr && (reg_addr == PIO_OFS_C_DIR);
  wire wr_e_dir = reg_wr && (reg_addr == PIO_OFS_E_DIR);

  // Zero-extended views of every port for the read path.
  wire [DW-1:0] a_dir = DW'(port_a_direction_ff);
  wire [DW-1:0] b_dir = DW'(port_b_direction_ff);
  wire [DW-1:0] c_dir = DW'(port_c_direction_ff);
  wire [DW-1:0] e_dir = DW'(port_e_direction_ff);
  wire [DW-1:0] a_rd  = pio_mux(a_dir, DW'(port_a_latch_ff),
                                DW'(pa_in));
  wire [DW-1:0] b_rd  = pio_mux(b_dir, DW'(port_b_latch_ff),
                                DW'(pb_in));
  wire [DW-1:0] c_rd  = pio_mux(c_dir, DW'(port_c_latch_ff),
                                DW'(pc_in));
  wire [DW-1:0] e_rd  = pio_mux(e_dir, DW'(port_e_latch_ff),
                                DW'(pe_in));
  wire [DW-1:0] d_rd  = DW'(pd_in);

  // Read data selection; unmapped indices read as zero.
  always_comb begin
    nxt_reg_rdata = reg_rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        PIO_OFS_A_LATCH: nxt_reg_rdata = a_rd;
        PIO_OFS_B_LATCH: nxt_reg_rdata = b_rd;
        PIO_OFS_C_LATCH: nxt_reg_rdata = c_rd;
        PIO_OFS_D_INPUT: nxt_reg_rdata = d_rd;
        PIO_OFS_A_DIR:   nxt_reg_rdata = a_dir;
        PIO_OFS_B_DIR:   nxt_reg_rdata = b_dir;
        PIO_OFS_C_DIR:   nxt_reg_rdata = c_dir;
        PIO_OFS_E_DIR:   nxt_reg_rdata = e_dir;
        PIO_OFS_E_LATCH: nxt_reg_rdata = e_rd;
        default:         nxt_reg_rdata = '0;
      endcase
    end
  end

  // Read data register, valid the cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  // Port A data latch: written whatever the direction, never reset, so a
  // level loaded before reset still drives once the pin turns output.
  always_ff @(posedge clk) begin
    if (wr_a_lat) begin
      port_a_latch_ff <= reg_wdata[PA_W-1:0];
    end
  end

  // Port B data latch: same behaviour as port A.
  always_ff @(posedge clk) begin
    if (wr_b_lat) begin
      port_b_latch_ff <= reg_wdata[PB_W-1:0];
    end
  end

  // Port C data latch: seven bits, the top bit of a write is dropped.
  always_ff @(posedge clk) begin
    if (wr_c_lat) begin
      port_c_latch_ff <= reg_wdata[PC_W-1:0];
    end
  end

  // Port D latch: storage only, the read path always shows the pins.
  always_ff @(posedge clk) begin
    if (wr_d_lat) begin
      port_d_input_ff <= reg_wdata[PD_W-1:0];
    end
  end

  // Port E data latch: feeds every pin not claimed by a peripheral.
  always_ff @(posedge clk) begin
    if (wr_e_lat) begin
      port_e_latch_ff <= reg_wdata[PE_W-1:0];
    end
  end

  // Port A direction: reset clears it so that every pin listens.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_direction_ff <= PIO_DIR_RST[PA_W-1:0];
    end else if (wr_a_dir) begin
      port_a_direction_ff <= reg_wdata[PA_W-1:0];
    end
  end

  // Port B direction: reset clears it so that every pin listens.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_direction_ff <= PIO_DIR_RST[PB_W-1:0];
    end else if (wr_b_dir) begin
      port_b_direction_ff <= reg_wdata[PB_W-1:0];
    end
  end

  // Port C direction: reset clears it so that every pin listens.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_c_direction_ff <= PIO_DIR_RST[PC_W-1:0];
    end else if (wr_c_dir) begin
      port_c_direction_ff <= reg_wdata[PC_W-1:0];
    end
  end

  // Port E direction: reset clears it; claimed pins ignore it for drive.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_e_direction_ff <= PIO_DIR_RST[PE_W-1:0];
    end else if (wr_e_dir) begin
      port_e_direction_ff <= reg_wdata[PE_W-1:0];
    end
  end

  // Port A pin slices: the enable is the direction bit itself, so a
  // cleared bit leaves the pin to whatever drives it from outside.
  for (genvar gi = 0; gi < PA_W; gi++) begin : g_pa_pin
    assign pa_oe[gi]  = port_a_direction_ff[gi];
    assign pa_out[gi] = port_a_latch_ff[gi];
  end

  // Port B pin slices, built like port A.
  for (genvar gi = 0; gi < PB_W; gi++) begin : g_pb_pin
    assign pb_oe[gi]  = port_b_direction_ff[gi];
    assign pb_out[gi] = port_b_latch_ff[gi];
  end

  // Port C pin slices, built like port A.
  for (genvar gi = 0; gi < PC_W; gi++) begin : g_pc_pin
    assign pc_oe[gi]  = port_c_direction_ff[gi];
    assign pc_out[gi] = port_c_latch_ff[gi];
  end

  // Port E pin slices: a claimed pin takes the peripheral's enable and
  // value; the direction bit then only steers what a read returns.
  for (genvar gi = 0; gi < PE_W; gi++) begin : g_pe_pin
    wire own = pe_periph_own[gi];
    assign pe_oe[gi]  = own ? pe_periph_oe[gi]
                            : port_e_direction_ff[gi];
    assign pe_out[gi] = own ? pe_periph_out[gi]
                            : port_e_latch_ff[gi];
  end

endmodule : pio_ports

// file: bench/pio_ports_chk.sv
// Purpose: Assertions on the pins and register port of the port block.
// Assumes: The block is built with its default port widths.
// Notes:   Bound into every instance of the block.
module pio_ports_chk import pio_pkg::*; (
  // All ports of the block, seen as inputs.
  input wire logic       clk, rst_n, reg_wr, reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, pa_in, pa_out, pa_oe,
  input wire logic [7:0] pb_in, pb_out, pb_oe, pe_in, pe_out, pe_oe,
  input wire logic [6:0] pc_in, pc_out, pc_oe, pd_in,
  input wire logic [7:0] pe_periph_own, pe_periph_oe, pe_periph_out
);
  // Every check runs on the bus clock and sleeps in reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  dir_reset_a: assert property ($rose(rst_n) |-> !(pa_oe|pb_oe|pc_oe))
    else $error("enable set after reset");
  a_dir_a: assert property (reg_wr && reg_addr == PIO_OFS_A_DIR |=>
    pa_oe == $past(reg_wdata)) else $error("port a enable wrong");
  c_dir_a: assert property (reg_wr && reg_addr == PIO_OFS_C_DIR |=>
    pc_oe == $past(reg_wdata[6:0])) else $error("port c enable wrong");
  oe_hold_a: assert property ($changed(pa_oe) |->
    $past(reg_wr && reg_addr == PIO_OFS_A_DIR)) else $error("stray enable");
  a_latch_a: assert property (reg_wr && reg_addr == PIO_OFS_A_LATCH |=>
    pa_out == $past(reg_wdata)) else $error("port a latch wrong");
  a_read_a: assert property (reg_rd && reg_addr == PIO_OFS_A_LATCH |=>
    reg_rdata == $past(pa_out & pa_oe | pa_in & ~pa_oe))
    else $error("port a read wrong");
  b_read_a: assert property (reg_rd && reg_addr == PIO_OFS_B_LATCH |=>
    reg_rdata == $past(pb_out & pb_oe | pb_in & ~pb_oe))
    else $error("port b read wrong");
  d_read_a: assert property (reg_rd && reg_addr == PIO_OFS_D_INPUT |=>
    reg_rdata == {1'b0, $past(pd_in)}) else $error("port d read wrong");
  e_own_a: assert property ((pe_oe & pe_periph_own) ==
    (pe_periph_oe & pe_periph_own)) else $error("owned enable wrong");
  // Main scenarios reached.
  cover property (reg_wr && reg_addr == PIO_OFS_E_DIR);
  cover property (reg_rd && reg_addr == PIO_OFS_A_LATCH);
  cover property (pe_periph_own != 8'h00 && pe_oe != 8'h00);
endmodule : pio_ports_chk

bind pio_ports pio_ports_chk i_chk (.*);

// file: bench/pio_pins.sv
// Purpose: Board and pin model on the far side of the port block.
// Assumes: A driven pin reads back its drive value.
// Notes:   Fight makes outside drivers win, to tell latch from pin.
module pio_pins (
  // Outside levels and the fight control.
  input  wire logic       fight,
  input  wire logic [7:0] ext_a, ext_b, ext_e, pa_out, pa_oe, pb_out, pb_oe,
  input  wire logic [7:0] pe_out, pe_oe,
  input  wire logic [6:0] ext_c, ext_d, pc_out, pc_oe,
  // Pin levels seen by the block.
  output logic      [7:0] pa_in, pb_in, pe_in,
  output logic      [6:0] pc_in, pd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unless fight is set, each wire carries the block's drive where enabled, else the outside.
  assign pa_in = fight ? ext_a : pa_out & pa_oe | ext_a & ~pa_oe;
  assign pb_in = fight ? ext_b : pb_out & pb_oe | ext_b & ~pb_oe;
  assign pc_in = fight ? ext_c : pc_out & pc_oe | ext_c & ~pc_oe;
  assign pe_in = fight ? ext_e : pe_out & pe_oe | ext_e & ~pe_oe;
  assign pd_in = ext_d;
endmodule : pio_pins

// file: bench/testbench.sv
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Reads answer in the cycle after the strobe.
// Notes:   Expected values are worked out by hand from the port rules.
module testbench import pio_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, fight = 0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, ext_a = '0, ext_b = '0, ext_e = '0;
  logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pe_in, pe_out;
  logic [7:0] pe_oe, pe_periph_own = '0, pe_periph_oe = '0, pe_periph_out = '0;
  logic [6:0] pc_in, pc_out, pc_oe, pd_in, ext_c = '0, ext_d = '0;
  int         miscompares = 0, check_count = 0;
  pio_ports i_dut (.*);
  pio_pins  i_pins (.*);
  // Bus clock of 40 ns.
  initial forever #20 clk = ~clk;
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] e, string n);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask : rd
  task automatic t_reset;
    chk("enables", 8'h00, pa_oe | pb_oe | pe_oe | pc_oe);
    rd(PIO_OFS_E_DIR, 8'h00, "dir e");
    rd(4'hF, 8'h00, "unmapped");
  endtask : t_reset
  task automatic t_a;
    wr(PIO_OFS_A_LATCH, 8'hA5);
    chk("out a", 8'hA5, pa_out);
    wr(PIO_OFS_A_DIR, 8'hF0);
    chk("oe a", 8'hF0, pa_oe);
    ext_a = 8'h3C;
    fight = 1'b1;
    rd(PIO_OFS_A_LATCH, 8'hAC, "read a");
  endtask : t_a
  task automatic t_bc;
    ext_b = 8'hC3;
    ext_c = 7'h55;
    wr(PIO_OFS_B_LATCH, 8'h5A);
    wr(PIO_OFS_B_DIR, 8'h0F);
    rd(PIO_OFS_B_LATCH, 8'hCA, "read b");
    wr(PIO_OFS_C_LATCH, 8'hFF);
    wr(PIO_OFS_C_DIR, 8'h02);
    rd(PIO_OFS_C_LATCH, 8'h57, "read c");
  endtask : t_bc
  task automatic t_d;
    ext_d = 7'h2A;
    wr(PIO_OFS_D_INPUT, 8'h7F);
    rd(PIO_OFS_D_INPUT, 8'h2A, "read d");
  endtask : t_d
  task automatic t_e;
    ext_e = 8'h5A;
    wr(PIO_OFS_E_LATCH, 8'h96);
    wr(PIO_OFS_E_DIR, 8'h07);
    rd(PIO_OFS_E_LATCH, 8'h5E, "read e");
    pe_periph_own = 8'hF0;
    pe_periph_oe  = 8'hA0;
    pe_periph_out = 8'hFF;
    #1 chk("oe e", 8'hA7, pe_oe);
    chk("out e", 8'hF6, pe_out);
    rd(PIO_OFS_E_LATCH, 8'h5E, "owned e");
  endtask : t_e
  task automatic t_rst2;
    rst_n = 1'b0;
    #1 chk("reset oe", 8'h00, pa_oe | pb_oe | pc_oe);
    chk("kept a", 8'hA5, pa_out);
    chk("kept bc", 8'h7F, pb_out | pc_out);
    chk("reset oe e", 8'hA0, pe_oe);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(PIO_OFS_C_DIR, 8'h00, "dir c");
  endtask : t_rst2
  task automatic conclude;
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_a;
    t_bc;
    t_d;
    t_e;
    t_rst2;
    conclude;
  end
endmodule : testbench
